// ---- core/uart_baud_pkg.sv ----
// shared constants and carrier types for the baud and interrupt-enable block
package uart_baud_pkg;

  // ----------------------------------------------------------------
  // register indices inside one port block
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_DIV_LOW = 4'h0; // divisor low byte while access bit set
  localparam logic [3:0] IDX_DIV_HIGH = 4'h1; // divisor high byte while access bit set
  localparam logic [3:0] IDX_IRQ_ENABLE = 4'h1; // interrupt enable while access bit clear

  // ----------------------------------------------------------------
  // field positions in the interrupt enable register
  // ----------------------------------------------------------------
  localparam int EN_RX_TRIGGER = 0; // receive fifo trigger level
  localparam int EN_THR_EMPTY = 1; // transmit holding register empty
  localparam int EN_RX_CHAR = 2; // received character available
  localparam int EN_CTS_DELTA = 3; // cts changed since last status read
  localparam int EN_SLEEP = 4; // sleep mode request
  localparam int EN_XOFF = 5; // pause character match
  localparam int EN_RTS_RISE = 6; // rts rising edge
  localparam int EN_CTS_RISE = 7; // cts rising edge
  localparam logic [7:0] EN_SOURCE_MASK = 8'hEF; // every bit that gates a source
  localparam logic [7:0] EN_UNLOCK_MASK = 8'hF0; // bits that need the unlock bit

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
  localparam logic [7:0] DIV_BYTE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // timing counts in sampling and reference clocks, reference rate
  // ----------------------------------------------------------------
  localparam int OVERSAMPLE = 16; // sampling clocks per bit
  localparam logic [3:0] START_CENTER = 4'h7; // last count before start-bit centre
  localparam logic [3:0] BIT_LAST = 4'hF; // last count of a bit cell
  localparam logic [1:0] PRESCALE_LAST = 2'h3; // divide by four
  localparam real REF_CLOCK_MHZ = 14.7456; // reference oscillator rate

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr; // write strobe, one cycle
    logic rd; // read strobe, one cycle
    logic [3:0] idx; // register index
    logic [7:0] wdata; // write data
  } reg_req_s;

  typedef struct packed {
    logic divisor_access; // line control bit 7
    logic prescale_sel; // modem control bit 7
    logic irq_output_en; // modem control bit 3
    logic enhanced_unlock; // enhanced feature bit 4
    logic fifo_enable; // fifo control bit 0
    logic sw_flow_en; // software flow control active
  } ctrl_bits_s;

  typedef struct packed {
    logic rx_at_trigger; // receive fifo at or above trigger
    logic thr_empty; // line status holding-empty flag
    logic xoff_match; // pause characters matched
    logic msr_read; // modem status read, one cycle
    logic isr_read; // interrupt status read, one cycle
    logic rbr_read; // receive buffer read, one cycle
  } src_in_s;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } rx_state_e;

endpackage

// ---- core/baud_divider.sv ----
// baud divider: reference ticks to 16x sampling ticks
`timescale 1ns/1ps
`default_nettype none
module baud_divider
  import uart_baud_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // reference and control
  input wire logic ref_tick,
  input wire logic run,
  input wire logic prescale_sel,
  input wire logic load,
  input wire logic [15:0] divisor,
  // output
  output logic sample_tick
);

  logic [1:0] pre_cnt_r; // prescale counter
  logic [15:0] baud_cnt_r; // main down counter
  logic stage_tick; // tick after prescale

  // divide by four only when prescale is selected
  assign stage_tick = run && ref_tick && (!prescale_sel || pre_cnt_r == PRESCALE_LAST); // RL7

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_cnt_r <= 2'h0;
    end else if (load || !prescale_sel) begin
      pre_cnt_r <= 2'h0;
    end else if (run && ref_tick) begin
      pre_cnt_r <= pre_cnt_r + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // down counter, reloaded by latch writes and on terminal count
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      baud_cnt_r <= 16'h0000;
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= 1'b0;
      if (load) begin
        baud_cnt_r <= divisor; // RL5
      end else if (stage_tick && divisor != 16'h0000) begin
        if (baud_cnt_r <= 16'h0001) begin
          baud_cnt_r <= divisor; // RL1 RL6
          sample_tick <= 1'b1; // RL2
        end else begin
          baud_cnt_r <= baud_cnt_r - 16'h0001;
        end
      end
    end
  end

endmodule // baud_divider
`default_nettype wire

// ---- core/uart_baud_irq.sv ----
// divisor latches, receiver start timing and interrupt enables of one port
// Operation
// RL1: divide reference clock by programmed divisor
// RL2: sampling clock is sixteen times bit rate
// RL3: divisor held in low and high byte
// RL4: divisor reached only with access bit set
// RL5: latch write reloads baud counter at once
// RL6: any divisor from one to maximum
// RL7: prescale bit adds divide by four
// RL8: software programs divisor from standard table
// RL9: falling edge resets counter, count to centre
// RL10: count 0 to 15 per following bit
// RL11: reject start bit high at centre
// RL12: each enable gates its source, shared line
// RL13: all enables low inhibit status and request
// RL14: request needs interrupt output enable bit
// RL15: receive trigger interrupt with fifo enabled
// RL16: interrupt while holding register is empty
// RL17: interrupt when received character available
// RL18: interrupt when cts changed since read
// RL19: sleep when enabled, not while pending
// RL20: cts change wakes port from sleep
// RL21: interrupt on pause character match
// RL22: interrupt on rts rising edge
// RL23: interrupt on cts rising edge
// RL24: enable bits 4 to 7 need unlock
// RL25: enables clear to zero on reset
`timescale 1ns/1ps
`default_nettype none
module uart_baud_irq
  import uart_baud_pkg::*;
#(
  parameter int DATA_BITS = 8 // character length
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port
  input wire reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  // control bits from neighbouring registers
  input wire ctrl_bits_s ctrl,
  // reference oscillator tick
  input wire logic ref_tick,
  // serial and modem lines
  input wire logic rxd,
  input wire logic rts,
  input wire logic cts,
  // interrupt sources and status reads
  input wire src_in_s src_in,
  // received character
  output logic [7:0] rx_data,
  output logic rx_done,
  output logic rx_frame_err,
  // status
  output logic sample_tick,
  output logic sleep_active,
  output logic int_pending,
  output logic irq_req_n
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] div_low_r; // divisor low byte
  logic [7:0] div_high_r; // divisor high byte
  logic [7:0] ier_r; // interrupt enables
  logic wr_div_low; // write to low latch
  logic wr_div_high; // write to high latch
  logic wr_ier; // write to enables
  logic rd_rbr; // read of receive buffer
  logic cts_prev_r; // cts one cycle ago
  logic rts_prev_r; // rts one cycle ago
  logic cts_delta_r; // cts changed since status read
  logic cts_rise_r; // cts rising edge seen
  logic rts_rise_r; // rts rising edge seen
  logic rx_avail_r; // character waiting
  logic cts_change; // cts toggled this cycle
  logic sleep_r; // sleep state
  logic wake_hold_r; // woken, hold off sleep until enables rewritten
  logic [7:0] sources; // raw source levels
  rx_state_e state_r; // receiver state
  logic [3:0] smp_cnt_r; // sampling clock counter
  logic [3:0] bit_cnt_r; // data bits taken
  logic [7:0] shift_r; // assembling character
  logic rxd_prev_r; // rxd one cycle ago
  logic rx_fall; // falling edge on rxd
  logic [15:0] div_next; // divisor including this cycle's latch write

  // decode register accesses
  assign wr_div_low = reg_req.wr && ctrl.divisor_access && reg_req.idx == IDX_DIV_LOW; // RL4
  assign wr_div_high = reg_req.wr && ctrl.divisor_access && reg_req.idx == IDX_DIV_HIGH; // RL4
  assign wr_ier = reg_req.wr && !ctrl.divisor_access && reg_req.idx == IDX_IRQ_ENABLE;
  assign rd_rbr = src_in.rbr_read;
  assign cts_change = cts != cts_prev_r;
  assign rx_fall = rxd_prev_r && !rxd;
  // reload must see the byte being written, not the stale latch
  assign div_next = {(wr_div_high ? reg_req.wdata : div_high_r),
    (wr_div_low ? reg_req.wdata : div_low_r)}; // RL5

  // ----------------------------------------------------------------
  // divisor latches
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_low_r <= DIV_BYTE_RESET;
      div_high_r <= DIV_BYTE_RESET;
    end else begin
      if (wr_div_low) begin
        div_low_r <= reg_req.wdata; // RL3
      end
      if (wr_div_high) begin
        div_high_r <= reg_req.wdata; // RL3
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt enable register, upper half locked
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ier_r <= IRQ_ENABLE_RESET; // RL25
    end else if (wr_ier) begin
      if (ctrl.enhanced_unlock) begin
        ier_r <= reg_req.wdata;
      end else begin
        ier_r <= (ier_r & EN_UNLOCK_MASK) | (reg_req.wdata & ~EN_UNLOCK_MASK); // RL24
      end
    end
  end

  // ----------------------------------------------------------------
  // read data, registered on the read strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      if (ctrl.divisor_access && reg_req.idx == IDX_DIV_LOW) begin
        reg_rdata <= div_low_r; // RL4
      end else if (ctrl.divisor_access && reg_req.idx == IDX_DIV_HIGH) begin
        reg_rdata <= div_high_r;
      end else if (reg_req.idx == IDX_IRQ_ENABLE) begin
        reg_rdata <= ier_r;
      end else begin
        reg_rdata <= 8'h00; // other registers live elsewhere
      end
    end
  end

  // ----------------------------------------------------------------
  // baud generator, stopped in sleep
  // ----------------------------------------------------------------
  baud_divider u_baud (
    .clk(clk),
    .arst_n(arst_n),
    .ref_tick(ref_tick),
    .run(!sleep_r),
    .prescale_sel(ctrl.prescale_sel),
    .load(wr_div_low || wr_div_high),
    .divisor(div_next),
    .sample_tick(sample_tick)
  );

  // ----------------------------------------------------------------
  // modem line edge flags, set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cts_prev_r <= 1'b0;
      rts_prev_r <= 1'b0;
      cts_delta_r <= 1'b0;
      cts_rise_r <= 1'b0;
      rts_rise_r <= 1'b0;
    end else begin
      cts_prev_r <= cts;
      rts_prev_r <= rts;
      if (cts_change) begin
        cts_delta_r <= 1'b1; // RL18
      end else if (src_in.msr_read) begin
        cts_delta_r <= 1'b0;
      end
      if (cts && !cts_prev_r) begin
        cts_rise_r <= 1'b1; // RL23
      end else if (src_in.isr_read) begin
        cts_rise_r <= 1'b0;
      end
      if (rts && !rts_prev_r) begin
        rts_rise_r <= 1'b1; // RL22
      end else if (src_in.isr_read) begin
        rts_rise_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // received character flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_avail_r <= 1'b0;
    end else if (rx_done) begin
      rx_avail_r <= 1'b1; // RL17
    end else if (rd_rbr) begin
      rx_avail_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // source gating onto one request line
  // ----------------------------------------------------------------
  always_comb begin
    sources = 8'h00;
    sources[EN_RX_TRIGGER] = src_in.rx_at_trigger && ctrl.fifo_enable; // RL15
    sources[EN_THR_EMPTY] = src_in.thr_empty; // RL16
    sources[EN_RX_CHAR] = rx_avail_r; // RL17
    sources[EN_CTS_DELTA] = cts_delta_r; // RL18
    sources[EN_XOFF] = src_in.xoff_match && ctrl.sw_flow_en; // RL21
    sources[EN_RTS_RISE] = rts_rise_r; // RL22
    sources[EN_CTS_RISE] = cts_rise_r; // RL23
  end

  assign int_pending = |(sources & ier_r & EN_SOURCE_MASK); // RL12 RL13
  assign irq_req_n = !(int_pending && ctrl.irq_output_en); // RL14

  // ----------------------------------------------------------------
  // sleep control
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sleep_r <= 1'b0;
      wake_hold_r <= 1'b0;
    end else begin
      if (sleep_r && cts_change) begin
        sleep_r <= 1'b0; // RL20
        wake_hold_r <= 1'b1;
      end else if (!ier_r[EN_SLEEP]) begin
        sleep_r <= 1'b0;
      end else if (!sleep_r && !wake_hold_r && !int_pending) begin
        sleep_r <= 1'b1; // RL19
      end
      if (wr_ier) begin
        wake_hold_r <= 1'b0; // rewrite of enables re-arms sleep
      end
    end
  end

  assign sleep_active = sleep_r;

  // ----------------------------------------------------------------
  // receiver timing state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= RX_IDLE;
      smp_cnt_r <= 4'h0;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      rxd_prev_r <= 1'b1;
      rx_data <= 8'h00;
      rx_done <= 1'b0;
      rx_frame_err <= 1'b0;
    end else begin
      rxd_prev_r <= rxd;
      rx_done <= 1'b0;
      case (state_r)
        RX_IDLE: begin
          if (rx_fall) begin
            state_r <= RX_START; // RL9
            smp_cnt_r <= 4'h0;
          end
        end
        RX_START: begin
          if (sample_tick) begin
            if (smp_cnt_r == START_CENTER) begin
              smp_cnt_r <= 4'h0;
              bit_cnt_r <= 4'h0;
              state_r <= rxd ? RX_IDLE : RX_DATA; // RL11
            end else begin
              smp_cnt_r <= smp_cnt_r + 4'h1; // RL9
            end
          end
        end
        RX_DATA: begin
          if (sample_tick) begin
            if (smp_cnt_r == BIT_LAST) begin
              smp_cnt_r <= 4'h0; // RL10
              shift_r <= {rxd, shift_r[7:1]};
              bit_cnt_r <= bit_cnt_r + 4'h1;
              if (bit_cnt_r == 4'(DATA_BITS - 1)) begin
                state_r <= RX_STOP;
              end
            end else begin
              smp_cnt_r <= smp_cnt_r + 4'h1;
            end
          end
        end
        RX_STOP: begin
          if (sample_tick) begin
            if (smp_cnt_r == BIT_LAST) begin
              smp_cnt_r <= 4'h0;
              rx_data <= shift_r;
              rx_done <= 1'b1;
              rx_frame_err <= !rxd;
              state_r <= RX_IDLE;
            end else begin
              smp_cnt_r <= smp_cnt_r + 4'h1;
            end
          end
        end
        default: begin
          state_r <= RX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_div_write;
    @(posedge clk) disable iff (!arst_n)
    (reg_req.wr && ctrl.divisor_access && reg_req.idx == IDX_DIV_HIGH)
      |=> div_high_r == $past(reg_req.wdata);
  endproperty
  a_div_write: assert property (p_div_write) else $error("high latch not written"); // RL3

  property p_div_locked;
    @(posedge clk) disable iff (!arst_n)
    (reg_req.wr && !ctrl.divisor_access && reg_req.idx == IDX_DIV_LOW) |=> $stable(div_low_r);
  endproperty
  a_div_locked: assert property (p_div_locked) else $error("latch written without access"); // RL4

  property p_ier_lock;
    @(posedge clk) disable iff (!arst_n)
    (wr_ier && !ctrl.enhanced_unlock)
      |=> (ier_r[7:4] == $past(ier_r[7:4])) && (ier_r[3:0] == $past(reg_req.wdata[3:0]));
  endproperty
  a_ier_lock: assert property (p_ier_lock) else $error("locked enable bits changed"); // RL24

  property p_out_enable;
    @(posedge clk) disable iff (!arst_n)
    !irq_req_n |-> ctrl.irq_output_en && int_pending;
  endproperty
  a_out_enable: assert property (p_out_enable) else $error("request without output enable"); // RL14

  property p_all_off;
    @(posedge clk) disable iff (!arst_n)
    ((ier_r & EN_SOURCE_MASK) == 8'h00) |-> irq_req_n && !int_pending;
  endproperty
  a_all_off: assert property (p_all_off) else $error("request with all enables low"); // RL13

  property p_cts_rise;
    @(posedge clk) disable iff (!arst_n)
    (cts && !cts_prev_r && ier_r[EN_CTS_RISE] && ctrl.irq_output_en && !wr_ier)
      |=> !irq_req_n;
  endproperty
  a_cts_rise: assert property (p_cts_rise) else $error("cts rise raised no request"); // RL23

  property p_start_reset;
    @(posedge clk) disable iff (!arst_n)
    (state_r == RX_IDLE && rx_fall) |=> state_r == RX_START && smp_cnt_r == 4'h0;
  endproperty
  a_start_reset: assert property (p_start_reset) else $error("start edge missed"); // RL9

  property p_false_start;
    @(posedge clk) disable iff (!arst_n)
    (state_r == RX_START && sample_tick && smp_cnt_r == START_CENTER && rxd)
      |=> state_r == RX_IDLE ##1 !rx_done;
  endproperty
  a_false_start: assert property (p_false_start) else $error("false start accepted"); // RL11

  property p_bit_wrap;
    @(posedge clk) disable iff (!arst_n)
    (state_r == RX_DATA && sample_tick && smp_cnt_r == BIT_LAST) |=> smp_cnt_r == 4'h0;
  endproperty
  a_bit_wrap: assert property (p_bit_wrap) else $error("bit counter did not wrap"); // RL10

  property p_sleep_entry;
    @(posedge clk) disable iff (!arst_n)
    $rose(sleep_r) |-> !$past(int_pending) && $past(ier_r[EN_SLEEP]);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep while pending"); // RL19

  property p_wake;
    @(posedge clk) disable iff (!arst_n)
    (sleep_r && cts_change) |=> !sleep_r;
  endproperty
  a_wake: assert property (p_wake) else $error("cts change did not wake"); // RL20

endmodule // uart_baud_irq
`default_nettype wire

// ---- verif/remote_sender.sv ----
// far-side serial device that frames characters onto the receive line
`timescale 1ns/1ps
`default_nettype none
module remote_sender (
  // pacing clock
  input wire logic clk,
  // serial line toward the block
  output logic rxd
);
  // ----------------------------------------------------------------
  // line driver
  // ----------------------------------------------------------------
  initial rxd = 1'b1; // idle line is high

  // one frame, lsb first; spike gives a short low pulse and no frame
  task automatic send(input logic [7:0] ch, input int bit_cyc, input bit spike);
    int i;
    @(negedge clk) rxd = 1'b0;
    if (spike) begin
      repeat (2) @(negedge clk);
      rxd = 1'b1;
      repeat (10 * bit_cyc) @(negedge clk);
    end else begin
      repeat (bit_cyc) @(negedge clk);
      for (i = 0; i < 8; i++) begin
        rxd = ch[i];
        repeat (bit_cyc) @(negedge clk);
      end
      rxd = 1'b1; // stop bit, then idle
      repeat (2 * bit_cyc) @(negedge clk);
    end
  endtask
endmodule // remote_sender
`default_nettype wire

// ---- verif/uart_baud_and_interrupt_enable_tb.sv ----
// self-checking bench for the divisor, receiver timing and enable logic
`timescale 1ns/1ps
`default_nettype none
module uart_baud_and_interrupt_enable_tb;
  import uart_baud_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk, arst_n, ref_tick, rts, cts, rxd, rx_done, rx_frame_err;
  logic sample_tick, sleep_active, int_pending, irq_req_n;
  reg_req_s reg_req; // register requests
  ctrl_bits_s ctrl; // neighbouring control bits
  src_in_s src_in; // source levels and clears
  logic [7:0] reg_rdata, rx_data, got, v;
  int n_fail = 0, total_checks = 0, cyc = 0, n_rx = 0, gap, lag;

  uart_baud_irq dut (.clk(clk), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .ctrl(ctrl), .ref_tick(ref_tick), .rxd(rxd), .rts(rts), .cts(cts), .src_in(src_in),
    .rx_data(rx_data), .rx_done(rx_done), .rx_frame_err(rx_frame_err),
    .sample_tick(sample_tick), .sleep_active(sleep_active), .int_pending(int_pending),
    .irq_req_n(irq_req_n));
  remote_sender far (.clk(clk), .rxd(rxd));

  // ----------------------------------------------------------------
  // clock, watchdog, receive capture
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(negedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++; // run hung
      complete_run();
    end
    if (rx_done === 1'b1) begin
      got = rx_data;
      n_rx++;
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [3:0] idx, input logic [7:0] d);
    @(negedge clk) reg_req = '{wr: 1'b1, rd: 1'b0, idx: idx, wdata: d};
    @(negedge clk) reg_req.wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] idx, output logic [7:0] d);
    @(negedge clk) reg_req = '{wr: 1'b0, rd: 1'b1, idx: idx, wdata: 8'h00};
    @(negedge clk) reg_req.rd = 1'b0;
    @(negedge clk) d = reg_rdata;
  endtask
  // wait for a tick, then count cycles to the next one
  task automatic tick_gap();
    lag = 0;
    while (sample_tick !== 1'b1 && lag < 20000) begin
      @(negedge clk);
      lag++;
    end
    gap = 0;
    do begin
      @(negedge clk);
      gap++;
    end while (sample_tick !== 1'b1 && gap < 20000);
  endtask
  task automatic complete_run();
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd_reg(IDX_IRQ_ENABLE, v);
    chk("enable_reset", {8'h00, v}, {8'h00, IRQ_ENABLE_RESET});
    chk("irq_idle", {15'h0, irq_req_n}, 16'h0001);
  endtask
  task automatic t_divisor();
    ctrl.divisor_access = 1'b1;
    wr_reg(IDX_DIV_HIGH, 8'h12);
    wr_reg(IDX_DIV_LOW, 8'h00);
    rd_reg(IDX_DIV_HIGH, v);
    chk("div_high", {8'h00, v}, 16'h0012);
    rd_reg(IDX_DIV_LOW, v);
    chk("div_low", {8'h00, v}, 16'h0000);
    tick_gap();
    chk("gap_4608", 16'(gap), 16'd4608);
    wr_reg(IDX_DIV_HIGH, 8'h00);
    wr_reg(IDX_DIV_LOW, 8'h01);
    tick_gap();
    chk("reload_fast", 16'(lag < 3), 16'h0001);
    chk("gap_1", 16'(gap), 16'd1);
    ctrl.prescale_sel = 1'b1;
    tick_gap();
    chk("gap_pre", 16'(gap), 16'd4);
    ctrl.prescale_sel = 1'b0;
    wr_reg(IDX_DIV_LOW, 8'h04);
    tick_gap();
    chk("gap_4", 16'(gap), 16'd4);
    chk("reload_new", 16'(lag), 16'd4);
    ctrl.divisor_access = 1'b0;
    wr_reg(IDX_DIV_LOW, 8'h55);
    rd_reg(IDX_DIV_LOW, v);
    chk("div_hidden", {8'h00, v}, 16'h0000);
    ctrl.divisor_access = 1'b1;
    rd_reg(IDX_DIV_LOW, v);
    chk("div_kept", {8'h00, v}, 16'h0004);
  endtask
  task automatic t_rx();
    far.send(8'hA5, 64, 1'b0);
    chk("rx_char", {8'h00, got}, 16'h00A5);
    chk("rx_count", 16'(n_rx), 16'd1);
    chk("rx_ferr", {15'h0, rx_frame_err}, 16'h0000);
    far.send(8'h00, 64, 1'b1);
    chk("rx_spike", 16'(n_rx), 16'd1);
  endtask
  task automatic t_irq();
    ctrl.divisor_access = 1'b0;
    wr_reg(IDX_IRQ_ENABLE, 8'hF2);
    rd_reg(IDX_IRQ_ENABLE, v);
    chk("locked", {8'h00, v}, 16'h0002);
    src_in.thr_empty = 1'b1;
    @(negedge clk);
    chk("pend", {15'h0, int_pending}, 16'h0001);
    chk("gated", {15'h0, irq_req_n}, 16'h0001);
    ctrl.irq_output_en = 1'b1;
    @(negedge clk);
    chk("thr_irq", {15'h0, irq_req_n}, 16'h0000);
    wr_reg(IDX_IRQ_ENABLE, 8'h00);
    chk("all_off", {14'h0, int_pending, irq_req_n}, 16'h0001);
    ctrl.enhanced_unlock = 1'b1;
    wr_reg(IDX_IRQ_ENABLE, 8'h80);
    cts = 1'b1;
    repeat (2) @(negedge clk);
    chk("cts_rise", {15'h0, irq_req_n}, 16'h0000);
    src_in.isr_read = 1'b1;
    @(negedge clk) src_in.isr_read = 1'b0;
    @(negedge clk);
    chk("cts_clear", {15'h0, irq_req_n}, 16'h0001);
    wr_reg(IDX_IRQ_ENABLE, 8'h40);
    rts = 1'b1;
    repeat (2) @(negedge clk);
    chk("rts_rise", {15'h0, irq_req_n}, 16'h0000);
    wr_reg(IDX_IRQ_ENABLE, 8'h10);
    repeat (2) @(negedge clk);
    chk("sleep_in", {15'h0, sleep_active}, 16'h0001);
    cts = 1'b0;
    repeat (2) @(negedge clk);
    chk("sleep_wake", {15'h0, sleep_active}, 16'h0000);
    wr_reg(IDX_IRQ_ENABLE, 8'h08);
    chk("cts_delta", {15'h0, irq_req_n}, 16'h0000);
    src_in.msr_read = 1'b1;
    @(negedge clk) src_in.msr_read = 1'b0;
    chk("delta_clear", {15'h0, irq_req_n}, 16'h0001);
    wr_reg(IDX_IRQ_ENABLE, 8'h01);
    src_in.rx_at_trigger = 1'b1;
    @(negedge clk);
    chk("trig_nofifo", {15'h0, irq_req_n}, 16'h0001);
    ctrl.fifo_enable = 1'b1;
    @(negedge clk);
    chk("trig_irq", {15'h0, irq_req_n}, 16'h0000);
    src_in.rx_at_trigger = 1'b0;
    @(negedge clk);
    chk("trig_drop", {15'h0, irq_req_n}, 16'h0001);
    wr_reg(IDX_IRQ_ENABLE, 8'h04);
    chk("char_irq", {15'h0, irq_req_n}, 16'h0000);
    src_in.rbr_read = 1'b1;
    @(negedge clk) src_in.rbr_read = 1'b0;
    chk("char_clear", {15'h0, irq_req_n}, 16'h0001);
    wr_reg(IDX_IRQ_ENABLE, 8'h20);
    src_in.xoff_match = 1'b1;
    @(negedge clk);
    chk("xoff_noflow", {15'h0, irq_req_n}, 16'h0001);
    ctrl.sw_flow_en = 1'b1;
    @(negedge clk);
    chk("xoff_irq", {15'h0, irq_req_n}, 16'h0000);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    ref_tick = 1'b1;
    rts = 1'b0;
    cts = 1'b0;
    reg_req = '0;
    ctrl = '0;
    src_in = '0;
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    t_reset();
    t_divisor();
    t_rx();
    t_irq();
    arst_n = 1'b0; // mid-run reset must clear the enables again
    @(negedge clk) arst_n = 1'b1;
    t_reset();
    complete_run();
  end
endmodule // uart_baud_and_interrupt_enable_tb
`default_nettype wire
